// *** core/swc_ctrl.sv ***
// switch channel control: serial link, mapping, latched protection
// assumes protection comparators and supply sense arrive on pins
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module swc_ctrl
  import swc_pkg::*;
#(
  parameter int RESTART_CYCLES = RESTART_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  input wire logic direct_input_zero_i,
  input wire logic direct_input_one_i,
  input wire logic idle_i,
  input wire logic fail_safe_i,
  input wire logic vdd_ok_i,
  input wire logic [NCH-1:0] overload_trip_i,
  input wire logic [NCH-1:0] over_temp_i,
  input wire logic [NCH-1:0] off_state_mon_i,
  output logic [NCH-1:0] chan_on_o,
  output logic [NCH-1:0] open_load_test_current_o,
  output logic irq_o
);
  localparam int PIN_W = 9 + 3 * NCH;
  logic [PIN_W-1:0] pin_s;
  logic cs_n_s, sclk_s, si_s, in0_s, in1_s, idle_s, fs_s, vdd_s;
  logic [NCH-1:0] ovl_s, otmp_s, osm_s;
  logic frame_vld;
  logic [FRAME_BITS-1:0] frame;
  logic [FRAME_BITS-1:0] tx_q;
  logic [7:0] ctrl_q, map0_q, map1_q, olen_q;
  logic [7:0] ovl_q, otmp_q, off_state_monitor_flags_q;
  logic [2:0] rd_addr_q;
  logic [7:0] fr_data;
  logic [2:0] fr_addr;
  logic fr_wr;
  logic wr_ok;
  logic [7:0] want, drive, fs_in;
  logic [7:0] ovl_set, otmp_set, osm_set, clr_fault, pend, restart_clr;
  logic [31:0] rst_cnt_q;
  logic [FRAME_BITS-1:0] last_frame_q;
  logic [NIRQ-1:0] irq_stat_q, irq_mask_q, irq_ev;
  logic aw_have_q, w_have_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_wr;

  swc_sync #(
    .WIDTH(PIN_W)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({cs_n_i, sclk_i, si_i, direct_input_zero_i, direct_input_one_i,
          idle_i, fail_safe_i, vdd_ok_i, 1'b0, overload_trip_i,
          over_temp_i, off_state_mon_i}),
    .q_o(pin_s)
  );

  // chip select idles high: a reset-low sync stage reads as selected,
  // so the link also waits for the supply flag, which resets low
  assign cs_n_s = pin_s[PIN_W-1];
  assign sclk_s = pin_s[PIN_W-2];
  assign si_s = pin_s[PIN_W-3];
  assign in0_s = pin_s[PIN_W-4];
  assign in1_s = pin_s[PIN_W-5];
  assign idle_s = pin_s[PIN_W-6];
  assign fs_s = pin_s[PIN_W-7];
  assign vdd_s = pin_s[PIN_W-8];
  assign ovl_s = pin_s[3*NCH-1:2*NCH];
  assign otmp_s = pin_s[2*NCH-1:NCH];
  assign osm_s = pin_s[NCH-1:0];

  swc_spi_link u_link (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(vdd_s),
    .cs_n_i(cs_n_s),
    .sclk_i(sclk_s),
    .si_i(si_s),
    .tx_i(tx_q),
    .so_o(so_o),
    .so_oe_o(so_oe_o),
    .frame_vld_o(frame_vld),
    .frame_o(frame)
  );

  assign fr_wr = frame[FR_WR_BIT];
  assign fr_addr = frame[FR_AD_HI:FR_AD_LO];
  assign fr_data = frame[7:0];
  assign wr_ok = frame_vld & fr_wr & vdd_s;

  // serial registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= '0;
      map0_q <= MAP0_RST;
      map1_q <= MAP1_RST;
      olen_q <= '0;
    end else if (wr_ok) begin
      case (fr_addr)
        SA_CTRL: ctrl_q <= fr_data;
        SA_MAP0: map0_q <= fr_data;
        SA_MAP1: map1_q <= fr_data;
        SA_OLEN: olen_q <= fr_data;
        default: ;
      endcase
    end
  end

  assign clr_fault = (wr_ok && fr_addr == SA_OVL) ? fr_data : 8'h00;

  // answer word for the next frame: address and data of this request
  function automatic logic [7:0] sreg(input logic [2:0] a);
    case (a)
      SA_CTRL: sreg = ctrl_q;
      SA_MAP0: sreg = map0_q;
      SA_MAP1: sreg = map1_q;
      SA_OLEN: sreg = olen_q;
      SA_OVL: sreg = ovl_q;
      SA_OTMP: sreg = otmp_q;
      SA_OSM: sreg = off_state_monitor_flags_q;
      SA_INST: sreg = {4'h0, idle_s, fs_s, in1_s, in0_s};
      default: sreg = 8'h00;
    endcase
  endfunction

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_addr_q <= '0;
      tx_q <= '0;
    end else if (frame_vld) begin
      rd_addr_q <= fr_addr;
      tx_q <= {1'b0, fr_addr, 4'h0, sreg(fr_addr)};
    end
  end

  // channel demand before fault gating
  always_comb begin
    fs_in = 8'h00;
    fs_in[FS_CH0] = in0_s;
    fs_in[FS_CH1] = in1_s;
    if (idle_s) begin
      want = 8'h00;
    end else if (fs_s) begin
      want = fs_in;
    end else begin
      want = ctrl_q | (map0_q & {8{in0_s}}) | (map1_q & {8{in1_s}});
    end
  end

  assign drive = want & ~ovl_q & ~otmp_q;
  assign ovl_set = ovl_s & want;
  assign otmp_set = otmp_s;
  assign pend = ovl_q & fs_in & {8{fs_s & ~idle_s}};

  // one shared restart timer; it restarts whenever no channel waits
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_cnt_q <= '0;
    end else if (pend == 8'h00 || rst_cnt_q >= 32'(RESTART_CYCLES - 1)) begin
      rst_cnt_q <= '0;
    end else begin
      rst_cnt_q <= rst_cnt_q + 32'h1;
    end
  end

  assign restart_clr = (rst_cnt_q >= 32'(RESTART_CYCLES - 1)) ? pend : 8'h00;

  // fault latches: a new trip wins over a clear in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovl_q <= '0;
    end else begin
      ovl_q <= (ovl_q & ~clr_fault & ~restart_clr) | ovl_set;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      otmp_q <= '0;
    end else begin
      otmp_q <= (otmp_q & ~clr_fault) | otmp_set;
    end
  end

  // off-state monitor flags clear when the host reads them
  assign osm_set = osm_s & olen_q & ~drive;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      off_state_monitor_flags_q <= '0;
    end else if (frame_vld && fr_addr == SA_OSM && !fr_wr) begin
      off_state_monitor_flags_q <= osm_set;
    end else begin
      off_state_monitor_flags_q <= off_state_monitor_flags_q | osm_set;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chan_on_o <= '0;
      open_load_test_current_o <= '0;
    end else begin
      chan_on_o <= drive;
      open_load_test_current_o <= olen_q & ~drive;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_frame_q <= '0;
    end else if (frame_vld) begin
      last_frame_q <= frame;
    end
  end

  // interrupts
  assign irq_ev = {|(osm_set & ~off_state_monitor_flags_q),
                   |(otmp_set & ~otmp_q),
                   |(ovl_set & ~ovl_q),
                   frame_vld};

  // axi4-lite write: address and data taken in either order
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_wr) begin
        aw_have_q <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_wr) begin
        w_have_q <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_q == RA_IRQ_STAT ||
                      aw_addr_q == RA_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // status: set wins over a write-one clear
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= '0;
    end else if (do_wr && aw_addr_q == RA_IRQ_STAT && w_strb_q[0]) begin
      irq_stat_q <= (irq_stat_q & ~w_data_q[NIRQ-1:0]) | irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_q <= '0;
    end else if (do_wr && aw_addr_q == RA_IRQ_MASK && w_strb_q[0]) begin
      irq_mask_q <= w_data_q[NIRQ-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // axi4-lite read: one outstanding, answer one cycle after the address
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        RA_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat_q};
        RA_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask_q};
        RA_STATUS: s_axi_rdata <= {off_state_monitor_flags_q, otmp_q,
                                   ovl_q, chan_on_o};
        RA_FRAME: s_axi_rdata <= {16'h0, last_frame_q};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule // swc_ctrl

// *** include/swc_pkg.sv ***
// constants shared by the switch channel control block
// assumes one 125 MHz core clock and an AXI4-Lite register master
package swc_pkg;
  localparam int NCH = 8;
  localparam int FRAME_BITS = 16;
  localparam int CLK_MHZ = 125;
  // fail-safe restart time in microseconds, figure of our own
  localparam int RESTART_US = 10000;
  localparam int RESTART_CYC = RESTART_US * CLK_MHZ;
  // serial frame layout: [15] write, [14:12] address, [7:0] data
  localparam int FR_WR_BIT = 15;
  localparam int FR_AD_HI = 14;
  localparam int FR_AD_LO = 12;
  // serial register addresses
  localparam logic [2:0] SA_CTRL = 3'h0;
  localparam logic [2:0] SA_MAP0 = 3'h1;
  localparam logic [2:0] SA_MAP1 = 3'h2;
  localparam logic [2:0] SA_OLEN = 3'h3;
  localparam logic [2:0] SA_OVL = 3'h4;
  localparam logic [2:0] SA_OTMP = 3'h5;
  localparam logic [2:0] SA_OSM = 3'h6;
  localparam logic [2:0] SA_INST = 3'h7;
  // reset values and fail-safe channel numbers
  localparam logic [7:0] MAP0_RST = 8'h04;
  localparam logic [7:0] MAP1_RST = 8'h08;
  localparam int FS_CH0 = 2;
  localparam int FS_CH1 = 3;
  // axi register byte addresses
  localparam logic [3:0] RA_IRQ_STAT = 4'h0;
  localparam logic [3:0] RA_IRQ_MASK = 4'h4;
  localparam logic [3:0] RA_STATUS = 4'h8;
  localparam logic [3:0] RA_FRAME = 4'hc;
  // interrupt status bits
  localparam int IB_FRAME = 0;
  localparam int IB_OVL = 1;
  localparam int IB_OTMP = 2;
  localparam int IB_OSM = 3;
  localparam int NIRQ = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** core/swc_sync.sv ***
// two-flop synchroniser for a vector of unrelated levels
// assumes inputs come from pins outside the core clock domain
`timescale 1ns/10ps
module swc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // swc_sync

// *** core/swc_spi_link.sv ***
// serial link shifter: mode 0, msb first, 16-bit frames
// assumes sclk, si and cs_n already synchronised to the core clock
`timescale 1ns/10ps
module swc_spi_link
  import swc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  input wire logic [FRAME_BITS-1:0] tx_i,
  output logic so_o,
  output logic so_oe_o,
  output logic frame_vld_o,
  output logic [FRAME_BITS-1:0] frame_o
);
  logic sclk_q;
  logic cs_n_q;
  logic [FRAME_BITS-1:0] sh_q;
  logic [5:0] cnt_q;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;

  assign rise = sclk_i & ~sclk_q;
  assign fall = ~sclk_i & sclk_q;
  assign cs_fall = ~cs_n_i & cs_n_q;
  assign cs_rise = cs_n_i & ~cs_n_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sclk_q <= sclk_i;
      cs_n_q <= cs_n_i;
    end
  end

  // the word shifts straight through, so longer chains pass bits on
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_q <= '0;
      cnt_q <= '0;
    end else if (en_i && cs_fall) begin
      sh_q <= tx_i;
      cnt_q <= '0;
    end else if (en_i && !cs_n_i && rise) begin
      sh_q <= {sh_q[FRAME_BITS-2:0], si_i};
      if (cnt_q != 6'h3f) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      so_o <= 1'b0;
    end else if (cs_fall) begin
      so_o <= tx_i[FRAME_BITS-1];
    end else if (!cs_n_i && fall) begin
      so_o <= sh_q[FRAME_BITS-1];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      so_oe_o <= 1'b0;
    end else begin
      so_oe_o <= en_i & ~cs_n_i;
    end
  end

  // only a whole 16-bit frame is taken; other lengths are dropped
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_vld_o <= 1'b0;
      frame_o <= '0;
    end else begin
      frame_vld_o <= en_i & cs_rise & (cnt_q == 6'(FRAME_BITS));
      if (en_i && cs_rise) begin
        frame_o <= sh_q;
      end
    end
  end
endmodule // swc_spi_link

// *** tb/swc_ctrl_properties.sv ***
// port assertions for the switch channel control block
// assumes pins pass a two-flop sync and an output register
`timescale 1ns/10ps
module swc_ctrl_chk
  import swc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic idle_i,
  input wire logic fail_safe_i,
  input wire logic vdd_ok_i,
  input wire logic direct_input_zero_i,
  input wire logic [NCH-1:0] overload_trip_i,
  input wire logic [NCH-1:0] over_temp_i,
  input wire logic [NCH-1:0] chan_on_o,
  input wire logic [NCH-1:0] open_load_test_current_o,
  input wire logic so_oe_o,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  logic [NCH-1:0] h1_q, h2_q, h3_q, h4_q;
  logic [NCH-1:0] hit;
  assign hit = overload_trip_i | over_temp_i;
  // fault history reset to zero so nothing fires just after reset
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {h1_q, h2_q, h3_q, h4_q} <= '0;
    end else begin
      {h1_q, h2_q, h3_q, h4_q} <= {hit, h1_q, h2_q, h3_q};
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_so_float: assert property (cs_n_i [*4] |-> !so_oe_o)
    else $error("serial output driven while deselected");
  a_so_drive: assert property ((!cs_n_i && vdd_ok_i) [*5] |-> so_oe_o)
    else $error("serial output not driven while selected");
  a_link_supply: assert property ((!vdd_ok_i) [*4] |-> !so_oe_o)
    else $error("serial output driven without supply");
  a_idle_off: assert property (idle_i [*4] |-> chan_on_o == '0)
    else $error("channel on in idle mode");
  a_fs_only: assert property (fail_safe_i [*4] |->
    (chan_on_o & 8'hf3) == '0)
    else $error("channel outside fail-safe pair on");
  a_fs_zero: assert property (
    (fail_safe_i && !direct_input_zero_i) [*4] |-> !chan_on_o[FS_CH0])
    else $error("fail-safe channel on with its input low");
  a_fault_off: assert property (fail_safe_i ||
    (hit & h1_q & h2_q & h3_q & h4_q & chan_on_o) == '0)
    else $error("channel on during a held fault");
  a_test_off: assert property
    ((open_load_test_current_o & chan_on_o & $past(chan_on_o)) == '0)
    else $error("test current on a channel that is on");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
endmodule // swc_ctrl_chk
bind swc_ctrl swc_ctrl_chk u_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
  .idle_i(idle_i), .fail_safe_i(fail_safe_i), .vdd_ok_i(vdd_ok_i),
  .direct_input_zero_i(direct_input_zero_i),
  .overload_trip_i(overload_trip_i), .over_temp_i(over_temp_i),
  .chan_on_o(chan_on_o), .so_oe_o(so_oe_o),
  .open_load_test_current_o(open_load_test_current_o),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);

// *** tb/swc_host_model.sv ***
// host serial master for the switch channel control block
// assumes mode 0 timing; clock stands low outside frames
`timescale 1ns/10ps
module swc_host_model (
  output logic cs_n_o,
  output logic sclk_o,
  output logic si_o,
  input wire logic so_i
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end
  // 160 ns period keeps the link clock under its ceiling
  // calls start on a core clock edge, so pins move by non-blocking
  // assignment to stay clear of the sampling flops
  task automatic xfer(input int n, input logic [31:0] tx,
                      output logic [31:0] rx);
    rx = '0;
    cs_n_o <= 1'b0;
    #80;
    for (int i = n - 1; i >= 0; i--) begin
      si_o <= tx[i];
      #80 sclk_o <= 1'b1;
      rx = {rx[30:0], so_i};
      #80 sclk_o <= 1'b0;
    end
    si_o <= 1'b0;
    #80 cs_n_o <= 1'b1;
    #80;
  endtask
endmodule // swc_host_model

// *** tb/swc_ctrl_tb.sv ***
// self-checking bench for the switch channel control block
// assumes the host model on the serial pins, 125 MHz core clock
`timescale 1ns/10ps
module swc_ctrl_tb
  import swc_pkg::*;
;
  localparam int RC = 20;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic dir_zero = 0, dir_one = 0, idle = 0, fs = 0, vdd = 1;
  logic [NCH-1:0] trip = '0, otmp = '0, osm = '0;
  logic awready, wready, bvalid, arready, rvalid, cs_n, sclk, si, so, irq;
  logic so_oe;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [NCH-1:0] chan_on, olt;
  logic [15:0] ans;
  int mismatches = 0;
  int n_tests = 0;
  always #4 core_clk = ~core_clk;
  swc_ctrl #(.RESTART_CYCLES(RC)) u_dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si),
    .so_o(so), .so_oe_o(so_oe), .direct_input_zero_i(dir_zero),
    .direct_input_one_i(dir_one), .idle_i(idle), .fail_safe_i(fs),
    .vdd_ok_i(vdd), .overload_trip_i(trip), .over_temp_i(otmp),
    .off_state_mon_i(osm), .chan_on_o(chan_on),
    .open_load_test_current_o(olt), .irq_o(irq)
  );
  // a released output reads back as the inverse of its last bit
  swc_host_model u_host (
    .cs_n_o(cs_n),
    .sclk_o(sclk),
    .si_o(si),
    .so_i(so_oe ? so : ~so)
  );
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // waits for the answer; only the watchdog ends a hung transfer
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // pin order {supply, idle, fail-safe, input one, input zero}
  task automatic pins(input logic [4:0] v, input logic [7:0] exp);
    @(posedge core_clk);
    {vdd, idle, fs, dir_one, dir_zero} <= v;
    cyc(6);
    chk(32'(chan_on), 32'(exp));
  endtask
  // order {monitor, temperature, overload}, held long enough to latch
  task automatic fault(input logic [23:0] v);
    @(posedge core_clk);
    {osm, otmp, trip} <= v;
    cyc(6);
    {osm, otmp, trip} <= '0;
    cyc(6);
  endtask
  task automatic sp(input logic [15:0] w);
    logic [31:0] r;
    u_host.xfer(16, 32'(w), r);
    ans = r[15:0];
  endtask
  task automatic sp_wr(input logic [2:0] a, input logic [7:0] d);
    sp({1'b1, a, 4'h0, d});
  endtask
  // the answer to a read arrives in the following frame
  task automatic sp_rd(input logic [2:0] a, input logic [7:0] exp);
    sp({1'b0, a, 12'h0});
    sp({1'b0, SA_INST, 12'h0});
    chk(32'(ans), 32'({1'b0, a, 4'h0, exp}));
  endtask
  initial begin
    #400000;
    mismatches++;
    $display("wrong value at %0t: watchdog expired", $time);
    close_out();
  end
  initial begin
    logic [31:0] r;
    cyc(16);
    rst_n <= 1'b1;
    cyc(4);
    axi_rd(RA_IRQ_MASK);
    chk(rd, 32'h0);
    sp_rd(SA_MAP0, MAP0_RST);
    sp_rd(SA_MAP1, MAP1_RST);
    pins(5'b10001, 8'h04);
    pins(5'b10011, 8'h0c);
    pins(5'b00011, 8'h0c);
    $display("test default routing done");
    pins(5'b10000, 8'h00);
    sp_wr(SA_MAP0, 8'h31);
    sp_wr(SA_CTRL, 8'h80);
    pins(5'b10001, 8'hb1);
    pins(5'b10000, 8'h80);
    sp_rd(SA_MAP0, 8'h31);
    $display("test mapping done");
    pins(5'b10101, 8'h04);
    pins(5'b10110, 8'h08);
    pins(5'b00101, 8'h04);
    pins(5'b01101, 8'h00);
    pins(5'b00001, 8'hb1);
    sp_wr(SA_CTRL, 8'hff);
    pins(5'b10001, 8'hb1);
    u_host.xfer(15, 32'h0000_7fff, r);
    u_host.xfer(32, 32'h80ff_1234, r);
    chk(32'(r[15:0]), 32'h80ff);
    pins(5'b10001, 8'hb1);
    $display("test fail-safe and link done");
    fault(24'h000080);
    pins(5'b10001, 8'h31);
    sp_rd(SA_OVL, 8'h80);
    axi_rd(RA_IRQ_STAT);
    chk(32'(rd[IB_OVL]), 32'h1);
    chk(32'(irq), 32'h0);
    axi_wr(RA_IRQ_MASK, 32'h2);
    cyc(3);
    chk(32'(irq), 32'h1);
    axi_wr(RA_IRQ_STAT, 32'h2);
    chk(32'(resp), 32'(RESP_OKAY));
    cyc(3);
    chk(32'(irq), 32'h0);
    sp_wr(SA_OVL, 8'h80);
    pins(5'b10001, 8'hb1);
    fault(24'h000100);
    pins(5'b10001, 8'hb0);
    sp_rd(SA_OTMP, 8'h01);
    sp_wr(SA_OVL, 8'h01);
    pins(5'b10001, 8'hb1);
    $display("test protection done");
    pins(5'b10101, 8'h04);
    fault(24'h000004);
    chk(32'(chan_on), 32'h00);
    cyc(3 * RC);
    chk(32'(chan_on), 32'h04);
    pins(5'b10000, 8'h80);
    sp_wr(SA_OLEN, 8'h81);
    cyc(3);
    chk(32'(olt), 32'h01);
    fault(24'h010000);
    sp_rd(SA_OSM, 8'h01);
    sp_rd(SA_OSM, 8'h00);
    axi_wr(RA_STATUS, 32'hffff_ffff);
    chk(32'(resp), 32'(RESP_SLVERR));
    axi_rd(RA_STATUS);
    chk(32'(rd[7:0]), 32'h80);
    $display("test open load and registers done");
    close_out();
  end
endmodule // swc_ctrl_tb
